// >>> rtl/pin_function_and_reset_straps.sv
// Pin function multiplexing, direction and pull control, reset strap capture
`timescale 1ns/1ps
`include "pin_straps_defines.svh"
module pin_function_and_reset_straps
    import pin_straps_pkg::*;
(
    input  wire logic                 SYS_CLK_I,
    input  wire logic                 RESET_I,
    // Strap-only pins outside this block
    input  wire logic                 PORT_SEL_STRAP_I,
    input  wire logic                 HOST_SI_PAD_I,
    input  wire logic                 HOST_SS_PAD_I,
    // Strap results
    output logic                      STRAPS_VALID_O,
    output logic                      IO_MODE_O,
    output logic                      HOST_PROTOCOL_SELECT_O,
    output logic                      HOST_CLOCK_POLARITY_O,
    output logic [`TWA_W-1:0]         TWOWIRE_SLAVE_ADDR_O,
    // Core side, external memory master
    input  wire logic [`ADDR_W-1:0]   MEM_ADDR_I,
    input  wire logic                 MEM_ADDR_EN_I,
    input  wire logic [`DATA_W-1:0]   MEM_DATA_OUT_I,
    input  wire logic                 MEM_DATA_OE_I,
    output logic [`DATA_W-1:0]        MEM_DATA_O,
    input  wire logic                 MEM_CS_I,
    input  wire logic                 MEM_RD_I,
    input  wire logic                 MEM_WR_I,
    // Core side, parallel I/O slave
    input  wire logic [7:0]           IO_PORT_DATA_OUT_I,
    input  wire logic                 IO_PORT_DATA_OE_I,
    output logic [7:0]                IO_PORT_DATA_O,
    input  wire logic                 PORT_READY_I,
    output logic                      CMD_DATA_SELECT_O,
    output logic                      PORT_ERROR_O,
    output logic                      HOST_CS_O,
    output logic                      HOST_RD_O,
    output logic                      HOST_WR_O,
    // Parallel port pads
    output logic [`ADDR_W-1:0]        PAD_A_O,
    output logic                      PAD_A_OE_O,
    input  wire logic [`DATA_W-1:0]   PAD_D_I,
    output logic [`DATA_W-1:0]        PAD_D_O,
    output logic [`DATA_W-1:0]        PAD_D_OE_O,
    output logic [`DATA_W-1:0]        PAD_D_PD_O,
    input  wire logic [2:0]           PAD_STB_I,
    output logic [2:0]                PAD_STB_O,
    output logic [2:0]                PAD_STB_OE_O,
    output logic [2:0]                PAD_STB_PU_O,
    // Core side, serial audio
    input  wire logic                 SER_IN_MASTER_I,
    input  wire logic                 SER_OUT_MASTER_I,
    input  wire logic                 MCLK_OUT_EN_I,
    input  wire logic                 IN_WORD_SYNC_OUT_I,
    input  wire logic                 IN_BIT_CLOCK_OUT_I,
    input  wire logic                 OUT_WORD_SYNC_OUT_I,
    input  wire logic                 OUT_BIT_CLOCK_OUT_I,
    input  wire logic                 OUT_MASTER_CLOCK_OUT_I,
    input  wire logic                 FRONT_DATA_I,
    input  wire logic                 SURROUND_DATA_I,
    input  wire logic                 CENTER_SUB_DATA_I,
    input  wire logic                 G_OR_SPDIF_DATA_I,
    output logic                      IN_WORD_SYNC_O,
    output logic                      IN_BIT_CLOCK_O,
    output logic                      OUT_WORD_SYNC_O,
    output logic                      OUT_BIT_CLOCK_O,
    output logic                      OUT_MASTER_CLOCK_O,
    output logic                      SERIAL_IN_A_O,
    output logic                      SERIAL_IN_E_O,
    output logic                      SERIAL_IN_F_O,
    output logic                      SPDIF_RX_O,
    // Serial audio pads
    input  wire logic                 PAD_SERIAL_IN_A_I,
    input  wire logic                 PAD_SERIAL_IN_E_I,
    input  wire logic                 PAD_SERIAL_IN_F_I,
    input  wire logic                 PAD_SPDIF_RX_IN_I,
    input  wire logic [1:0]           PAD_IN_SYNC_CLK_I,
    output logic [1:0]                PAD_IN_SYNC_CLK_O,
    output logic [1:0]                PAD_IN_SYNC_CLK_OE_O,
    output logic [1:0]                PAD_IN_SYNC_CLK_PD_O,
    input  wire logic [1:0]           PAD_OUT_SYNC_CLK_I,
    output logic [1:0]                PAD_OUT_SYNC_CLK_O,
    output logic [1:0]                PAD_OUT_SYNC_CLK_OE_O,
    output logic [1:0]                PAD_OUT_SYNC_CLK_PD_O,
    input  wire logic                 PAD_MCLK_I,
    output logic                      PAD_MCLK_O,
    output logic                      PAD_MCLK_OE_O,
    input  wire logic [3:0]           PAD_SER_OUT_I,
    output logic [3:0]                PAD_SER_OUT_O,
    output logic [3:0]                PAD_SER_OUT_OE_O,
    output logic [2:0]                PAD_SER_OUT_PU_O
);

    // Synchronised pad inputs
    logic [`SYNC_W-1:0] pad_async;
    logic [`SYNC_W-1:0] pad_sync;

    assign pad_async = {PORT_SEL_STRAP_I, HOST_SI_PAD_I, HOST_SS_PAD_I, PAD_SER_OUT_I,
                        PAD_SERIAL_IN_A_I, PAD_SERIAL_IN_E_I, PAD_SERIAL_IN_F_I,
                        PAD_SPDIF_RX_IN_I, PAD_IN_SYNC_CLK_I, PAD_OUT_SYNC_CLK_I,
                        PAD_MCLK_I, PAD_STB_I, PAD_D_I};

    pin_input_sync #(
        .WIDTH   (`SYNC_W)
    ) u_sync (
        .clk_i   (SYS_CLK_I),
        .rst_i   (RESET_I),
        .async_i (pad_async),
        .sync_o  (pad_sync)
    );

    logic             port_sel_s;
    logic             si_s;
    logic             ss_s;
    logic [3:0]       ser_out_s;

    assign port_sel_s = pad_sync[50];
    assign si_s       = pad_sync[49];
    assign ss_s       = pad_sync[48];
    assign ser_out_s  = pad_sync[47:44];

    // Pin inputs only pass through the synchroniser toward the core
    assign SERIAL_IN_A_O      = pad_sync[43];                  // [RULE18]
    assign SERIAL_IN_E_O      = pad_sync[42];                  // [RULE18]
    assign SERIAL_IN_F_O      = pad_sync[41];                  // [RULE18]
    assign SPDIF_RX_O         = pad_sync[40];                  // [RULE18]
    assign IN_WORD_SYNC_O     = pad_sync[39];
    assign IN_BIT_CLOCK_O     = pad_sync[38];
    assign OUT_WORD_SYNC_O    = pad_sync[37];
    assign OUT_BIT_CLOCK_O    = pad_sync[36];
    assign OUT_MASTER_CLOCK_O = pad_sync[35];
    assign HOST_CS_O          = pad_sync[34];                  // [RULE10]
    assign HOST_RD_O          = pad_sync[33];                  // [RULE10]
    assign HOST_WR_O          = pad_sync[32];                  // [RULE10]
    assign MEM_DATA_O         = pad_sync[31:0];                // [RULE9]
    assign IO_PORT_DATA_O     = pad_sync[`D_PP_MSB:`D_PP_LSB]; // [RULE9]
    assign CMD_DATA_SELECT_O  = pad_sync[`D_CMD_BIT];          // [RULE7]
    assign PORT_ERROR_O       = pad_sync[`D_ERR_BIT];          // [RULE8]

    // Strap capture sequencer
    strap_state_e state_r;
    strap_state_e state_nxt;
    logic [1:0]   settle_r;
    logic [1:0]   settle_nxt;
    logic         capture;
    logic         run;
    logic         mem_mode;
    logic         io_mode;

    // Sampling waits for the synchroniser to fill after release, so a reset
    // strap is never read from the flops' reset constant
    always_comb begin
        state_nxt  = state_r;
        settle_nxt = settle_r;
        case (state_r)
            ST_RESET_HOLD: begin
                state_nxt  = ST_SETTLE;
                settle_nxt = 2'h0;
            end
            ST_SETTLE: begin
                settle_nxt = settle_r + 2'h1;
                if (settle_r == `STRAP_SETTLE_CYCLES) begin
                    state_nxt = ST_RUN;
                end
            end
            ST_RUN: begin
                state_nxt = ST_RUN;
            end
            default: begin
                state_nxt = ST_RESET_HOLD;
            end
        endcase
    end

    assign capture  = (state_r == ST_SETTLE) && (settle_r == `STRAP_SETTLE_CYCLES);
    assign run      = (state_r == ST_RUN);
    assign io_mode  = IO_MODE_O == `PORT_MODE_IO;
    assign mem_mode = run && !io_mode;

    always_ff @(posedge SYS_CLK_I or posedge RESET_I) begin
        if (RESET_I) begin
            state_r  <= ST_RESET_HOLD;
            settle_r <= 2'h0;
        end else begin
            state_r  <= state_nxt;
            settle_r <= settle_nxt;
        end
    end

    // Strap registers: loaded once, then frozen until the next reset
    logic [`TWA_W-1:0] twa_nxt;

    always_comb begin
        twa_nxt                    = '0;                       // [RULE20]
        twa_nxt[`TWA_BIT_SI]       = si_s;                     // [RULE20]
        twa_nxt[`TWA_BIT_SS]       = ss_s;                     // [RULE20]
        twa_nxt[`TWA_BIT_CENTER]   = ser_out_s[1];             // [RULE13]
        twa_nxt[`TWA_BIT_SURROUND] = ser_out_s[2];             // [RULE12]
    end

    always_ff @(posedge SYS_CLK_I or posedge RESET_I) begin
        if (RESET_I) begin
            STRAPS_VALID_O         <= 1'h0;
            IO_MODE_O              <= `PORT_MODE_MEM;
            HOST_PROTOCOL_SELECT_O <= `PROTO_SPI;
            HOST_CLOCK_POLARITY_O  <= 1'h0;
            TWOWIRE_SLAVE_ADDR_O   <= '0;
        end else if (capture) begin                            // [RULE22]
            STRAPS_VALID_O         <= 1'h1;
            IO_MODE_O              <= port_sel_s;              // [RULE4]
            HOST_PROTOCOL_SELECT_O <= ser_out_s[3];            // [RULE11]
            HOST_CLOCK_POLARITY_O  <= ser_out_s[0];            // [RULE14] [RULE21]
            TWOWIRE_SLAVE_ADDR_O   <= twa_nxt;
        end
    end

    // Data bus: one slice per bit picks memory or I/O function
    logic [`DATA_W-1:0] d_o_nxt;
    logic [`DATA_W-1:0] d_oe_nxt;
    logic [`DATA_W-1:0] d_pd_nxt;

    genvar gi;
    generate
        for (gi = 0; gi < `DATA_W; gi++) begin : g_dbit
            localparam bit IS_READY = (gi == `D_READY_BIT);
            localparam bit IS_PP    = (gi >= `D_PP_LSB) && (gi <= `D_PP_MSB);
            localparam bit HAS_PULL = 1'((`D_PULL_MASK >> gi) & 32'h0000_0001);
            // Clamped so bits outside the byte lane never form a negative index
            localparam int PP_IDX   = IS_PP ? (gi - `D_PP_LSB) : 0;
            wire io_oe = IS_READY ? 1'b1 : (IS_PP ? IO_PORT_DATA_OE_I : 1'b0);
            wire io_o  = IS_READY ? PORT_READY_I :
                         (IS_PP ? IO_PORT_DATA_OUT_I[PP_IDX] : 1'b0);
            assign d_oe_nxt[gi] = mem_mode ? MEM_DATA_OE_I : (run && io_oe); // [RULE6] [RULE9]
            assign d_o_nxt[gi]  = mem_mode ? MEM_DATA_OUT_I[gi] : io_o;      // [RULE6] [RULE9]
            assign d_pd_nxt[gi] = HAS_PULL && run && io_mode && !d_oe_nxt[gi]; // [RULE3]
        end
    endgenerate

    // Strobes are outputs only as memory master; pull-ups fill the gaps
    logic [2:0] stb_oe_nxt;
    assign stb_oe_nxt = mem_mode ? 3'h7 : 3'h0;                // [RULE10]

    // Serial direction controls; everything stays an input until the straps are in
    logic [1:0] in_grp_oe_nxt;
    logic [1:0] out_grp_oe_nxt;
    logic       mclk_oe_nxt;
    logic [3:0] ser_oe_nxt;

    assign in_grp_oe_nxt  = {2{run && SER_IN_MASTER_I}};       // [RULE15]
    assign out_grp_oe_nxt = {2{run && SER_OUT_MASTER_I}};      // [RULE16]
    assign mclk_oe_nxt    = run && MCLK_OUT_EN_I;              // [RULE17]
    assign ser_oe_nxt     = {4{run}};                          // [RULE11] [RULE12] [RULE13]

    // Every pad control is registered; reset leaves all drivers off
    always_ff @(posedge SYS_CLK_I or posedge RESET_I) begin
        if (RESET_I) begin
            PAD_A_O    <= '0;                                  // [RULE5]
            PAD_A_OE_O <= 1'h0;                                // [RULE1]
            PAD_D_O    <= '0;
            PAD_D_OE_O <= '0;                                  // [RULE1]
            PAD_D_PD_O <= '0;
        end else begin
            PAD_A_O    <= mem_mode ? MEM_ADDR_I : '0;          // [RULE5]
            PAD_A_OE_O <= mem_mode && MEM_ADDR_EN_I;           // [RULE5]
            PAD_D_O    <= d_o_nxt;
            PAD_D_OE_O <= d_oe_nxt;
            PAD_D_PD_O <= d_pd_nxt;                            // [RULE2]
        end
    end

    always_ff @(posedge SYS_CLK_I or posedge RESET_I) begin
        if (RESET_I) begin
            PAD_STB_O    <= 3'h7;
            PAD_STB_OE_O <= 3'h0;                              // [RULE1]
            PAD_STB_PU_O <= 3'h7;
        end else begin
            PAD_STB_O    <= {MEM_CS_I, MEM_RD_I, MEM_WR_I};
            PAD_STB_OE_O <= stb_oe_nxt;
            PAD_STB_PU_O <= ~stb_oe_nxt;                       // [RULE2]
        end
    end

    always_ff @(posedge SYS_CLK_I or posedge RESET_I) begin
        if (RESET_I) begin
            PAD_IN_SYNC_CLK_O     <= 2'h0;
            PAD_IN_SYNC_CLK_OE_O  <= 2'h0;                     // [RULE1] [RULE15]
            PAD_IN_SYNC_CLK_PD_O  <= 2'h3;
            PAD_OUT_SYNC_CLK_O    <= 2'h0;
            PAD_OUT_SYNC_CLK_OE_O <= 2'h0;                     // [RULE1] [RULE16]
            PAD_OUT_SYNC_CLK_PD_O <= 2'h3;
            PAD_MCLK_O            <= 1'h0;
            PAD_MCLK_OE_O         <= 1'h0;                     // [RULE17]
        end else begin
            PAD_IN_SYNC_CLK_O     <= {IN_WORD_SYNC_OUT_I, IN_BIT_CLOCK_OUT_I};
            PAD_IN_SYNC_CLK_OE_O  <= in_grp_oe_nxt;
            PAD_IN_SYNC_CLK_PD_O  <= ~in_grp_oe_nxt;           // [RULE2]
            PAD_OUT_SYNC_CLK_O    <= {OUT_WORD_SYNC_OUT_I, OUT_BIT_CLOCK_OUT_I};
            PAD_OUT_SYNC_CLK_OE_O <= out_grp_oe_nxt;
            PAD_OUT_SYNC_CLK_PD_O <= ~out_grp_oe_nxt;          // [RULE2]
            PAD_MCLK_O            <= OUT_MASTER_CLOCK_OUT_I;
            PAD_MCLK_OE_O         <= mclk_oe_nxt;
        end
    end

    // Serial data outputs double as straps, so they float while sampling
    always_ff @(posedge SYS_CLK_I or posedge RESET_I) begin
        if (RESET_I) begin
            PAD_SER_OUT_O    <= 4'h0;
            PAD_SER_OUT_OE_O <= 4'h0;
            PAD_SER_OUT_PU_O <= 3'h7;
        end else begin
            PAD_SER_OUT_O    <= {FRONT_DATA_I, SURROUND_DATA_I, CENTER_SUB_DATA_I,
                                 G_OR_SPDIF_DATA_I};
            PAD_SER_OUT_OE_O <= ser_oe_nxt;                    // [RULE14]
            PAD_SER_OUT_PU_O <= ~ser_oe_nxt[3:1];              // [RULE2] [RULE19]
        end
    end

    // Checks
    reset_float_a: assert property (@(posedge SYS_CLK_I) // [RULE1]
        RESET_I |-> (PAD_D_OE_O == '0) && !PAD_A_OE_O && (PAD_STB_OE_O == 3'h0))
        else $error("Pad driven during reset");

    pull_excl_a: assert property (@(posedge SYS_CLK_I) disable iff (RESET_I) // [RULE2]
        ((PAD_D_PD_O & PAD_D_OE_O) == '0) && ((PAD_STB_PU_O & PAD_STB_OE_O) == 3'h0)
        && ((PAD_IN_SYNC_CLK_PD_O & PAD_IN_SYNC_CLK_OE_O) == 2'h0))
        else $error("Pull active on a driving pad");

    d_pull_mode_a: assert property (@(posedge SYS_CLK_I) disable iff (RESET_I) // [RULE3]
        ((PAD_D_PD_O & ~`D_PULL_MASK) == '0) && (IO_MODE_O || (PAD_D_PD_O == '0)))
        else $error("Data pull-down outside parallel I/O mode");

    mode_capture_a: assert property (@(posedge SYS_CLK_I) disable iff (RESET_I) // [RULE4]
        $rose(STRAPS_VALID_O) |-> (IO_MODE_O == $past(port_sel_s))
        && (HOST_CLOCK_POLARITY_O == $past(ser_out_s[0])))
        else $error("Strap value not captured");

    ready_drive_a: assert property (@(posedge SYS_CLK_I) disable iff (RESET_I) // [RULE6]
        run && io_mode |=> PAD_D_OE_O[`D_READY_BIT]
        && (PAD_D_O[`D_READY_BIT] == $past(PORT_READY_I)))
        else $error("Ready output not driven in I/O mode");

    io_in_bits_a: assert property (@(posedge SYS_CLK_I) disable iff (RESET_I) // [RULE7]
        run && io_mode |=> !PAD_D_OE_O[`D_CMD_BIT] && !PAD_D_OE_O[`D_ERR_BIT])
        else $error("Host input bit driven in I/O mode");

    strobe_dir_a: assert property (@(posedge SYS_CLK_I) disable iff (RESET_I) // [RULE10]
        run |=> (PAD_STB_OE_O == ($past(io_mode) ? 3'h0 : 3'h7)))
        else $error("Strobe direction wrong for mode");

    addr_zero_a: assert property (@(posedge SYS_CLK_I) disable iff (RESET_I) // [RULE20]
        !TWOWIRE_SLAVE_ADDR_O[6] && !TWOWIRE_SLAVE_ADDR_O[3] && !TWOWIRE_SLAVE_ADDR_O[2])
        else $error("Fixed slave address bit set");

    strap_hold_a: assert property (@(posedge SYS_CLK_I) disable iff (RESET_I) // [RULE22]
        STRAPS_VALID_O |=> STRAPS_VALID_O && $stable(TWOWIRE_SLAVE_ADDR_O)
        && $stable(IO_MODE_O) && $stable(HOST_PROTOCOL_SELECT_O))
        else $error("Strap changed after capture");

    slave_group_a: assert property (@(posedge SYS_CLK_I) disable iff (RESET_I) // [RULE15]
        !SER_IN_MASTER_I |=> (PAD_IN_SYNC_CLK_OE_O == 2'h0) && (PAD_IN_SYNC_CLK_PD_O == 2'h3))
        else $error("Input group driven as slave");

endmodule : pin_function_and_reset_straps

// >>> rtl/pin_straps_defines.svh
// Constants for pin function multiplexing and reset strap sampling
// Functional notes
// [RULE1] In reset, tri-state pins float and two-way pins are inputs.
// [RULE2] A pin's pull is on only while the pin is an input.
// [RULE3] Pull-downs on D[31:15] and D[3:0] only in parallel I/O mode.
// [RULE4] Port select strap taken at reset: 0 external memory, 1 parallel I/O.
// [RULE5] Twenty-bit tri-statable address bus, zero right after reset.
// [RULE6] D14 is data in memory mode, port ready output in I/O mode.
// [RULE7] D13 is data in memory mode, command/data select input in I/O mode.
// [RULE8] D12 is data in memory mode, error input in I/O mode.
// [RULE9] D[11:4] carry memory data, or the I/O port byte lane.
// [RULE10] Chip select and strobes: outputs in memory mode, host inputs in I/O mode.
// [RULE11] Front pair pin picks host protocol at reset, then outputs port B data.
// [RULE12] Surround pin gives address bit 0 at reset, then outputs port C data.
// [RULE13] Center/sub pin gives address bit 1 at reset, then outputs port D data.
// [RULE14] Port G / S/PDIF pin sets host clock polarity at reset, then outputs.
// [RULE15] Input group sync and clock: outputs as master, inputs as slave and after reset.
// [RULE16] Output group sync and clock: outputs as master, inputs as slave and after reset.
// [RULE17] Master clock pin is output or input; input after reset.
// [RULE18] Serial inputs A, E, F and S/PDIF receive are input-only pins.
// [RULE19] Board pulls front pair pin low for two-wire, else it reads SPI.
// [RULE20] Slave address bits 5,4,1,0 from straps; bits 6,3,2 always zero.
// [RULE21] Host clock polarity is 1 when its strap pin is high, else 0.
// [RULE22] Straps taken once after reset release and held until next reset.
`ifndef PIN_STRAPS_DEFINES_SVH
`define PIN_STRAPS_DEFINES_SVH

`define ADDR_W              20
`define DATA_W              32
`define TWA_W               7
`define STRAP_SETTLE_CYCLES 2'h3
`define TWA_BIT_SI          5
`define TWA_BIT_SS          4
`define TWA_BIT_CENTER      1
`define TWA_BIT_SURROUND    0
`define D_PULL_MASK         32'hFFFF_800F
`define D_READY_BIT         14
`define D_CMD_BIT           13
`define D_ERR_BIT           12
`define D_PP_LSB            4
`define D_PP_MSB            11
`define PORT_MODE_MEM       1'h0
`define PORT_MODE_IO        1'h1
`define PROTO_TWOWIRE       1'h0
`define PROTO_SPI           1'h1
`define SYNC_W              51

`endif

// >>> rtl/pin_straps_pkg.sv
// Types shared by the pin multiplexer
package pin_straps_pkg;

    typedef enum logic [1:0] {
        ST_RESET_HOLD,
        ST_SETTLE,
        ST_RUN
    } strap_state_e;

endpackage : pin_straps_pkg

// >>> rtl/pin_input_sync.sv
// Two-flop synchroniser for a vector of pin inputs
`timescale 1ns/1ps
module pin_input_sync #(
    parameter int WIDTH = 8
) (
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    input  wire logic [WIDTH-1:0] async_i,
    output logic      [WIDTH-1:0] sync_o
);

    logic [WIDTH-1:0] meta_r;
    logic [WIDTH-1:0] sync_r;

    genvar gi;
    generate
        for (gi = 0; gi < WIDTH; gi++) begin : g_bit
            always_ff @(posedge clk_i or posedge rst_i) begin
                if (rst_i) begin
                    meta_r[gi] <= 1'h0;
                    sync_r[gi] <= 1'h0;
                end else begin
                    meta_r[gi] <= async_i[gi];
                    sync_r[gi] <= meta_r[gi];
                end
            end
        end
    endgenerate

    assign sync_o = sync_r;

endmodule : pin_input_sync

// >>> tb/pad_board_model.sv
// Board side of the pads: a pin reads its own drive, else what the board puts on it
`timescale 1ns/1ps
module pad_board_model #(
    parameter int W = 44
) (
    input  wire logic [W-1:0] oe_i,
    input  wire logic [W-1:0] drv_i,
    input  wire logic [W-1:0] ext_i,
    output logic      [W-1:0] lvl_o
);
    // Released pins follow ext_i, which changes every step, so a stale value never passes
    // Serial output strap levels (st) and host strobes ride on ext_i; port select, SI and SS straps drive the DUT directly
    assign lvl_o = (oe_i & drv_i) | (~oe_i & ext_i);
endmodule : pad_board_model

// >>> tb/pin_function_and_reset_straps_test.sv
// Self-checking bench for pin multiplexing and reset strap capture
`timescale 1ns/1ps
module pin_function_and_reset_straps_test;
    logic SYS_CLK_I = 1'b0, RESET_I = 1'b0;
    logic PORT_SEL_STRAP_I, HOST_SI_PAD_I, HOST_SS_PAD_I, MEM_ADDR_EN_I, MEM_DATA_OE_I;
    logic MEM_CS_I, MEM_RD_I, MEM_WR_I, IO_PORT_DATA_OE_I, PORT_READY_I, SER_IN_MASTER_I;
    logic SER_OUT_MASTER_I, MCLK_OUT_EN_I, IN_WORD_SYNC_OUT_I, IN_BIT_CLOCK_OUT_I;
    logic OUT_WORD_SYNC_OUT_I, OUT_BIT_CLOCK_OUT_I, OUT_MASTER_CLOCK_OUT_I, FRONT_DATA_I;
    logic SURROUND_DATA_I, CENTER_SUB_DATA_I, G_OR_SPDIF_DATA_I, PAD_SERIAL_IN_A_I;
    logic PAD_SERIAL_IN_E_I, PAD_SERIAL_IN_F_I, PAD_SPDIF_RX_IN_I, PAD_MCLK_I;
    logic STRAPS_VALID_O, IO_MODE_O, HOST_PROTOCOL_SELECT_O, HOST_CLOCK_POLARITY_O;
    logic PAD_A_OE_O, CMD_DATA_SELECT_O, PORT_ERROR_O, HOST_CS_O, HOST_RD_O, HOST_WR_O;
    logic IN_WORD_SYNC_O, IN_BIT_CLOCK_O, OUT_WORD_SYNC_O, OUT_BIT_CLOCK_O, OUT_MASTER_CLOCK_O;
    logic SERIAL_IN_A_O, SERIAL_IN_E_O, SERIAL_IN_F_O, SPDIF_RX_O, PAD_MCLK_O, PAD_MCLK_OE_O;
    logic [19:0] MEM_ADDR_I, PAD_A_O;
    logic [31:0] MEM_DATA_OUT_I, MEM_DATA_O, PAD_D_I, PAD_D_O, PAD_D_OE_O, PAD_D_PD_O;
    logic [7:0]  IO_PORT_DATA_OUT_I, IO_PORT_DATA_O;
    logic [6:0]  TWOWIRE_SLAVE_ADDR_O;
    logic [3:0]  PAD_SER_OUT_I, PAD_SER_OUT_O, PAD_SER_OUT_OE_O, st;
    logic [2:0]  PAD_STB_I, PAD_STB_O, PAD_STB_OE_O, PAD_STB_PU_O, PAD_SER_OUT_PU_O;
    logic [1:0]  PAD_IN_SYNC_CLK_I, PAD_IN_SYNC_CLK_O, PAD_IN_SYNC_CLK_OE_O;
    logic [1:0]  PAD_IN_SYNC_CLK_PD_O, PAD_OUT_SYNC_CLK_I, PAD_OUT_SYNC_CLK_O;
    logic [1:0]  PAD_OUT_SYNC_CLK_OE_O, PAD_OUT_SYNC_CLK_PD_O;
    logic [44:0] rv;
    logic [9:0]  s_exp;
    logic [31:0] d_oe;
    int          err_count = 0, tests_run = 0, mode;

    always #2.5 SYS_CLK_I = ~SYS_CLK_I;

    pad_board_model #(.W(44)) board (
        .oe_i ({PAD_D_OE_O, PAD_STB_OE_O, PAD_SER_OUT_OE_O, PAD_IN_SYNC_CLK_OE_O,
                PAD_OUT_SYNC_CLK_OE_O, PAD_MCLK_OE_O}),
        .drv_i({PAD_D_O, PAD_STB_O, PAD_SER_OUT_O, PAD_IN_SYNC_CLK_O, PAD_OUT_SYNC_CLK_O,
                PAD_MCLK_O}),
        .ext_i({rv[44:10], st, rv[4:0]}),
        .lvl_o({PAD_D_I, PAD_STB_I, PAD_SER_OUT_I, PAD_IN_SYNC_CLK_I, PAD_OUT_SYNC_CLK_I,
                PAD_MCLK_I}));
    pin_function_and_reset_straps dut (.*);

    task automatic chk(input logic [63:0] g, input logic [63:0] e);
        tests_run++;
        if (g !== e) begin
            err_count++;
            $display("Error at %0t: got %h expected %h", $time, g, e);
        end
    endtask : chk

    task automatic finish_test;
        $display("Checks %0d, errors %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : finish_test

    task automatic rnd;
        {MEM_ADDR_I, MEM_ADDR_EN_I, MEM_DATA_OUT_I, MEM_DATA_OE_I, MEM_CS_I, MEM_RD_I, MEM_WR_I,
         IO_PORT_DATA_OUT_I, IO_PORT_DATA_OE_I, PORT_READY_I, SER_IN_MASTER_I, SER_OUT_MASTER_I,
         MCLK_OUT_EN_I, IN_WORD_SYNC_OUT_I, IN_BIT_CLOCK_OUT_I, OUT_WORD_SYNC_OUT_I,
         OUT_BIT_CLOCK_OUT_I, OUT_MASTER_CLOCK_OUT_I, FRONT_DATA_I, SURROUND_DATA_I,
         CENTER_SUB_DATA_I, G_OR_SPDIF_DATA_I, PAD_SERIAL_IN_A_I, PAD_SERIAL_IN_E_I,
         PAD_SERIAL_IN_F_I, PAD_SPDIF_RX_IN_I, rv} <= {$urandom, $urandom, $urandom, $urandom};
    endtask : rnd

    task automatic check_reset;
        chk({STRAPS_VALID_O, PAD_A_OE_O, PAD_D_OE_O, PAD_STB_OE_O, PAD_SER_OUT_OE_O,
             PAD_IN_SYNC_CLK_OE_O, PAD_OUT_SYNC_CLK_OE_O, PAD_MCLK_OE_O}, 64'h0);
        chk({PAD_D_PD_O, PAD_STB_PU_O, PAD_SER_OUT_PU_O, PAD_IN_SYNC_CLK_PD_O,
             PAD_OUT_SYNC_CLK_PD_O}, 42'h3FF);
    endtask : check_reset

    task automatic check_run;
        // Pad drive in I/O mode is only the ready line and the byte lane
        d_oe = mode ? {17'h0, 1'b1, 2'h0, {8{IO_PORT_DATA_OE_I}}, 4'h0} : {32{MEM_DATA_OE_I}};
        chk({IO_MODE_O, HOST_PROTOCOL_SELECT_O, HOST_CLOCK_POLARITY_O, TWOWIRE_SLAVE_ADDR_O},
            s_exp);
        chk(PAD_D_OE_O, d_oe);
        chk(PAD_D_PD_O, mode ? 32'hFFFF_800F : 32'h0);
        chk({PAD_A_OE_O, PAD_STB_OE_O, PAD_STB_PU_O}, mode ? 7'h07 : {MEM_ADDR_EN_I, 6'h38});
        chk(PAD_A_O, mode ? 20'h0 : MEM_ADDR_I);
        if (mode == 0) chk(MEM_DATA_O, PAD_D_I);
        if (mode == 0) chk(PAD_STB_O, {MEM_CS_I, MEM_RD_I, MEM_WR_I});
        if (mode == 1) chk({HOST_CS_O, HOST_RD_O, HOST_WR_O}, PAD_STB_I);
        if (mode == 1) chk(PAD_D_O[14], PORT_READY_I);
        if (mode == 1) chk({CMD_DATA_SELECT_O, PORT_ERROR_O, IO_PORT_DATA_O}, PAD_D_I[13:4]);
        if (mode == 1 && IO_PORT_DATA_OE_I) chk(PAD_D_O[11:4], IO_PORT_DATA_OUT_I);
        chk({PAD_IN_SYNC_CLK_OE_O, PAD_IN_SYNC_CLK_PD_O, PAD_OUT_SYNC_CLK_OE_O,
             PAD_OUT_SYNC_CLK_PD_O, PAD_MCLK_OE_O}, {{2{SER_IN_MASTER_I}}, {2{!SER_IN_MASTER_I}},
             {2{SER_OUT_MASTER_I}}, {2{!SER_OUT_MASTER_I}}, MCLK_OUT_EN_I});
        chk({PAD_IN_SYNC_CLK_O, PAD_OUT_SYNC_CLK_O, PAD_MCLK_O}, {IN_WORD_SYNC_OUT_I,
             IN_BIT_CLOCK_OUT_I, OUT_WORD_SYNC_OUT_I, OUT_BIT_CLOCK_OUT_I,
             OUT_MASTER_CLOCK_OUT_I});
        chk({IN_WORD_SYNC_O, IN_BIT_CLOCK_O, OUT_WORD_SYNC_O, OUT_BIT_CLOCK_O,
             OUT_MASTER_CLOCK_O},
            {PAD_IN_SYNC_CLK_I, PAD_OUT_SYNC_CLK_I, PAD_MCLK_I});
        chk({PAD_SER_OUT_OE_O, PAD_SER_OUT_PU_O, PAD_SER_OUT_O}, {7'h78, FRONT_DATA_I,
             SURROUND_DATA_I, CENTER_SUB_DATA_I, G_OR_SPDIF_DATA_I});
        chk({SERIAL_IN_A_O, SERIAL_IN_E_O, SERIAL_IN_F_O, SPDIF_RX_O}, {PAD_SERIAL_IN_A_I,
             PAD_SERIAL_IN_E_I, PAD_SERIAL_IN_F_I, PAD_SPDIF_RX_IN_I});
    endtask : check_run

    initial begin
        void'($urandom(32'h8265_8dcb));
        // Raised in the NBA region so the asynchronous resets see an edge at time zero
        RESET_I <= 1'b1;
        {PORT_SEL_STRAP_I, HOST_SI_PAD_I, HOST_SS_PAD_I, st} = 7'h00;
        rnd();
        for (int r = 0; r < 4; r++) begin
            mode = r % 2;
            @(posedge SYS_CLK_I);
            RESET_I <= 1'b1;
            PORT_SEL_STRAP_I <= mode[0];
            {HOST_SI_PAD_I, HOST_SS_PAD_I, st} <= 6'($urandom);
            repeat (10) @(posedge SYS_CLK_I);
            #1 check_reset();
            s_exp = {mode[0], st[3], st[0], 1'b0, HOST_SI_PAD_I, HOST_SS_PAD_I, 2'b00, st[1], st[2]};
            @(posedge SYS_CLK_I);
            RESET_I <= 1'b0;
            for (int i = 0; i < 20 && STRAPS_VALID_O !== 1'b1; i++) @(posedge SYS_CLK_I);
            chk(STRAPS_VALID_O, 1'b1);
            // Strap pins move after capture; the latched values must not follow
            for (int i = 0; i < 25; i++) begin
                @(posedge SYS_CLK_I);
                rnd();
                {PORT_SEL_STRAP_I, HOST_SI_PAD_I, HOST_SS_PAD_I, st} <= 7'($urandom);
                repeat (4) @(posedge SYS_CLK_I);
                #1 check_run();
            end
        end
        finish_test();
    end

    initial begin
        #50000;
        err_count++;
        finish_test();
    end
endmodule : pin_function_and_reset_straps_test
